// ===== hw/umc_pkg.sv
// Package: register map, field positions and carriers for the mode control block
package umc_pkg;
    localparam int          ADDR_W         = 8;
    localparam int          DATA_W         = 32;
    localparam logic [7:0]  OFF_MODE_CTL2  = 8'h14;
    localparam logic [7:0]  OFF_GUARD_PSC  = 8'h18;
    localparam logic [7:0]  OFF_STATUS     = 8'h1C;
    localparam int          B_CTS_IRQ      = 10;
    localparam int          B_CTS_FLOW     = 9;
    localparam int          B_RTS_FLOW     = 8;
    localparam int          B_TX_DMA       = 7;
    localparam int          B_RX_DMA       = 6;
    localparam int          B_SMARTCARD    = 5;
    localparam int          B_NACK         = 4;
    localparam int          B_HALF_DUPLEX  = 3;
    localparam int          B_IR_LOWPOWER  = 2;
    localparam int          B_IR_ENABLE    = 1;
    localparam int          B_ERR_IRQ      = 0;
    localparam int          GUARD_LSB      = 8;
    localparam int          PSC_SC_MSB     = 4;
    localparam logic [10:0] CTL2_RESET     = 11'h000;
    localparam logic [15:0] GP_RESET       = 16'h0000;
    // Bits that may change only while the unit is disabled
    localparam logic [10:0] CTL2_LOCK_MASK = 11'h33E;
    // Bits absent on the simplified instances
    localparam logic [10:0] CTL2_SIMPLE_RSV = 11'h730;
    localparam logic [15:0] GP_SIMPLE_RSV   = 16'hFF00;

    typedef struct packed {
        logic cts_irq_enable;
        logic cts_flow_enable;
        logic rts_flow_enable;
        logic tx_dma_enable;
        logic rx_dma_enable;
        logic smartcard_enable;
        logic parity_nack_enable;
        logic half_duplex_enable;
        logic infrared_low_power;
        logic infrared_enable;
        logic error_irq_enable;
    } umc_ctl_s;

    typedef struct packed {
        logic [7:0] guard_time_field;
        logic [7:0] clock_divider_field;
    } umc_gp_s;

    typedef struct packed {
        logic cts_change_flag;
        logic framing_error_flag;
        logic overrun_error_flag;
        logic noise_error_flag;
        logic rx_buffer_full;
        logic tx_request;
        logic rx_request;
        logic parity_error;
        logic frame_done;
    } umc_stat_s;
endpackage

// ===== hw/umc_divider.sv
// Clock divider producing a one-cycle enable pulse and a toggled clock level
`timescale 1ns/1ps
module umc_divider #(
    parameter int W = 8
) (
    input  wire logic         ref_clk_in,
    input  wire logic         rstn_in,
    input  wire logic         run_in,
    input  wire logic [W-1:0] div_in,
    output logic              tick_out,
    output logic              level_out
);
    logic [W-1:0] cnt_r;
    logic         hit;

    assign hit = run_in && (div_in != '0) && (cnt_r >= div_in - W'(1));

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            cnt_r     <= '0;
            tick_out  <= 1'b0;
            level_out <= 1'b0;
        end else begin
            cnt_r     <= (!run_in || hit) ? '0 : cnt_r + W'(1);
            tick_out  <= hit;
            level_out <= run_in ? (level_out ^ hit) : 1'b0;
        end
    end
endmodule

// ===== hw/umc_mode_ctl.sv
// Mode control, guard time and prescaler logic of the serial transceiver
//
// Behaviour
// - CTS change flag raises interrupt when enabled
// - CTS flow enable makes CTS input matter
// - RTS flow enable drives RTS output
// - Transmit DMA requests only when enabled
// - Receive DMA requests only when enabled
// - Smartcard enable selects smartcard operation
// - NACK sent on parity error if enabled in smartcard mode
// - Half-duplex enable selects half-duplex operation
// - Low-power bit selects low-power infrared operation
// - Infrared enable turns on infrared coding
// - Error interrupt needs receive DMA and enable
// - Locked fields ignore writes while unit enabled
// - Guard time delays transmission complete flag in smartcard mode
// - Low-power clock divides by prescaler value
// - Smartcard clock divides by twice low bits
// - Prescaler high bits unused in smartcard
// - Simplified instances lack smartcard and flow controls
// - Second instance lacks infrared enable
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
module umc_mode_ctl
    import umc_pkg::*;
#(
    parameter bit SIMPLE_UART = 1'b0,
    parameter bit NO_INFRARED = 1'b0
) (
    input  wire logic                  ref_clk_in,
    input  wire logic                  rstn_in,
    input  wire logic [umc_pkg::ADDR_W-1:0] addr_in,
    input  wire logic [umc_pkg::DATA_W-1:0] wdata_in,
    input  wire logic                  wr_in,
    input  wire logic                  rd_in,
    output logic [umc_pkg::DATA_W-1:0] rdata_out,
    input  wire logic                  unit_enable_in,
    input  wire logic                  baud_tick_in,
    input  wire logic                  cts_n_in,
    input  wire umc_pkg::umc_stat_s    stat_in,
    output logic                       tx_hold_out,
    output logic                       rts_n_out,
    output logic                       tx_dma_req_out,
    output logic                       rx_dma_req_out,
    output logic                       nack_out,
    output logic                       transmission_complete_flag_out,
    output logic                       irq_out,
    output umc_pkg::umc_ctl_s          mode_out,
    output logic                       smartcard_clock_out,
    output logic                       lowpower_tick_out
);
    import umc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    umc_ctl_s     ctl_r;
    umc_gp_s      gp_r;
    logic         cts_meta_r;
    logic         cts_sync_r;
    logic         cts_prev_r;
    logic         cts_change_r;
    logic [7:0]   guard_cnt_r;
    logic         guard_busy_r;

    logic [10:0]  ctl_rsv;
    logic [15:0]  gp_rsv;
    logic [10:0]  ctl_wmask;
    logic [15:0]  gp_wmask;
    logic [10:0]  ctl_nxt;
    logic [15:0]  gp_nxt;
    logic         sel_ctl;
    logic         sel_gp;
    logic         sel_stat;
    logic [31:0]  rd_mux;
    logic         sc_on;
    logic         lp_on;
    logic [7:0]   sc_div;
    logic         sc_tick;
    logic         sc_level;
    logic         lp_tick;
    logic         lp_level;
    logic         cts_ok;
    logic         err_any;
    logic         guard_done;

    ////////////////////////////////////////////////////////////////////////
    // Register decode
    assign sel_ctl  = (addr_in == OFF_MODE_CTL2);
    assign sel_gp   = (addr_in == OFF_GUARD_PSC);
    assign sel_stat = (addr_in == OFF_STATUS);

    assign ctl_rsv = (SIMPLE_UART ? CTL2_SIMPLE_RSV : 11'h000)
                   | (NO_INFRARED ? 11'(1 << B_IR_ENABLE) : 11'h000);
    assign gp_rsv  = SIMPLE_UART ? GP_SIMPLE_RSV : 16'h0000;

    // Locked fields frozen while unit enabled
    assign ctl_wmask = ~ctl_rsv & (unit_enable_in ? ~CTL2_LOCK_MASK : 11'h7FF);
    assign gp_wmask  = ~gp_rsv & (unit_enable_in ? 16'h0000 : 16'hFFFF);
    assign ctl_nxt   = (ctl_r & ~ctl_wmask) | (wdata_in[10:0] & ctl_wmask);
    assign gp_nxt    = (gp_r & ~gp_wmask) | (wdata_in[15:0] & gp_wmask);

    assign rd_mux = sel_ctl  ? {21'h000000, ctl_r} :
                    sel_gp   ? {16'h0000, gp_r} :
                    sel_stat ? {27'h0000000, cts_change_r, guard_busy_r, cts_sync_r, lp_on, sc_on} :
                               32'h00000000;

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            ctl_r     <= CTL2_RESET;
            gp_r      <= GP_RESET;
            rdata_out <= 32'h00000000;
        end else begin
            if (wr_in && sel_ctl) begin
                ctl_r <= ctl_nxt;
            end
            if (wr_in && sel_gp) begin
                gp_r <= gp_nxt;
            end
            rdata_out <= rd_in ? rd_mux : 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // CTS pin synchroniser
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            cts_meta_r <= 1'b1;
            cts_sync_r <= 1'b1;
            cts_prev_r <= 1'b1;
        end else begin
            cts_meta_r <= cts_n_in;
            cts_sync_r <= cts_meta_r;
            cts_prev_r <= cts_sync_r;
        end
    end

    // Reading the status word clears the change flag; a new edge wins
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            cts_change_r <= 1'b0;
        end else if (ctl_r.cts_flow_enable && (cts_sync_r != cts_prev_r)) begin
            cts_change_r <= 1'b1;
        end else if (rd_in && sel_stat) begin
            cts_change_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode selection and flow control
    // Smartcard selection
    assign sc_on = ctl_r.smartcard_enable;
    assign lp_on = ctl_r.infrared_enable && ctl_r.infrared_low_power;
    // CTS gates new characters only when enabled
    assign cts_ok = !ctl_r.cts_flow_enable || !cts_sync_r;
    assign err_any = stat_in.framing_error_flag || stat_in.overrun_error_flag
                   || stat_in.noise_error_flag;

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            mode_out       <= '0;
            tx_hold_out    <= 1'b0;
            rts_n_out      <= 1'b0;
            tx_dma_req_out <= 1'b0;
            rx_dma_req_out <= 1'b0;
            nack_out       <= 1'b0;
            irq_out        <= 1'b0;
        end else begin
            mode_out    <= ctl_r;
            tx_hold_out <= !cts_ok;
            rts_n_out   <= ctl_r.rts_flow_enable && stat_in.rx_buffer_full;
            tx_dma_req_out <= ctl_r.tx_dma_enable && stat_in.tx_request;
            rx_dma_req_out <= ctl_r.rx_dma_enable && stat_in.rx_request;
            nack_out <= sc_on && ctl_r.parity_nack_enable && stat_in.parity_error;
            irq_out <= (ctl_r.cts_irq_enable && (stat_in.cts_change_flag || cts_change_r))
                     || (ctl_r.rx_dma_enable && ctl_r.error_irq_enable && err_any);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Guard time: counts baud ticks after each frame in smartcard mode
    assign guard_done = guard_busy_r && baud_tick_in && (guard_cnt_r <= 8'h01);

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            guard_cnt_r                    <= 8'h00;
            guard_busy_r                   <= 1'b0;
            transmission_complete_flag_out <= 1'b0;
        end else if (stat_in.frame_done) begin
            guard_cnt_r                    <= gp_r.guard_time_field;
            guard_busy_r                   <= sc_on && (gp_r.guard_time_field != 8'h00);
            transmission_complete_flag_out <= !(sc_on && (gp_r.guard_time_field != 8'h00));
        end else begin
            if (guard_busy_r && baud_tick_in) begin
                guard_cnt_r <= guard_cnt_r - 8'h01;
            end
            if (guard_done) begin
                guard_busy_r                   <= 1'b0;
                transmission_complete_flag_out <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Prescalers. A zero field stops the divider rather than hang it.
    // Low five bits only, half period per count
    assign sc_div = {3'b000, gp_r.clock_divider_field[PSC_SC_MSB:0]};

    umc_divider #(.W(8)) u_sc_div (
        .ref_clk_in (ref_clk_in),
        .rstn_in    (rstn_in),
        .run_in     (sc_on),
        .div_in     (sc_div),
        .tick_out   (sc_tick),
        .level_out  (sc_level)
    );

    umc_divider #(.W(8)) u_lp_div (
        .ref_clk_in (ref_clk_in),
        .rstn_in    (rstn_in),
        .run_in     (lp_on),
        .div_in     (gp_r.clock_divider_field),
        .tick_out   (lp_tick),
        .level_out  (lp_level)
    );

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            smartcard_clock_out <= 1'b0;
            lowpower_tick_out   <= 1'b0;
        end else begin
            smartcard_clock_out <= sc_level;
            lowpower_tick_out   <= lp_tick && !lp_level ? 1'b1 : lp_tick;
        end
    end
endmodule

// ===== tb/umc_far_model.sv
// Far side model: terminal that paces baud ticks and gates clear-to-send
`timescale 1ns/1ps
module umc_far_model #(
    parameter int BAUD_DIV = 4
) (
    input  wire logic ref_clk_in,
    input  wire logic rstn_in,
    input  wire logic stop_in,
    output logic      cts_n_out,
    output logic      baud_tick_out
);
    logic [7:0] cnt_r;
    wire        wrap = (cnt_r == 8'(BAUD_DIV - 1));
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            cnt_r <= 8'h00;
            baud_tick_out <= 1'b0;
            cts_n_out <= 1'b0;
        end else begin
            cnt_r <= wrap ? 8'h00 : cnt_r + 8'h01;
            baud_tick_out <= wrap;
            // Busy terminal holds clear-to-send high
            cts_n_out <= stop_in;
        end
    end
endmodule

// ===== tb/umc_mode_ctl_chk.sv
// Checker: port assertions for the mode control block
`timescale 1ns/1ps
module umc_mode_ctl_chk
    import umc_pkg::*;
(
    input wire logic              ref_clk_in,
    input wire logic              rstn_in,
    input wire logic              unit_enable_in,
    input wire umc_pkg::umc_stat_s stat_in,
    input wire logic              tx_dma_req_out,
    input wire logic              rx_dma_req_out,
    input wire logic              nack_out,
    input wire logic              rts_n_out,
    input wire logic              irq_out,
    input wire umc_pkg::umc_ctl_s mode_out,
    input wire logic              smartcard_clock_out,
    input wire logic              lowpower_tick_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);
    ////////////////////////////////////////////////////////////////
    property p_txdma; tx_dma_req_out |-> $past(stat_in.tx_request) && mode_out.tx_dma_enable; endproperty
    a_txdma: assert property (p_txdma) else $error("tx request without cause");
    property p_rxdma; rx_dma_req_out |-> $past(stat_in.rx_request) && mode_out.rx_dma_enable; endproperty
    a_rxdma: assert property (p_rxdma) else $error("rx request without cause");
    property p_nack; nack_out |-> $past(stat_in.parity_error) && mode_out.parity_nack_enable; endproperty
    a_nack: assert property (p_nack) else $error("nack without parity error");
    property p_rts; rts_n_out |-> $past(stat_in.rx_buffer_full) && mode_out.rts_flow_enable; endproperty
    a_rts: assert property (p_rts) else $error("rts dropped without full buffer");
    property p_irq; !(mode_out.error_irq_enable || mode_out.cts_irq_enable)[*2] |-> !irq_out; endproperty
    a_irq: assert property (p_irq) else $error("irq while both enables off");
    property p_lock; unit_enable_in[*3] |-> $stable(mode_out & CTL2_LOCK_MASK); endproperty
    a_lock: assert property (p_lock) else $error("locked field changed while enabled");
    property p_scclk; (!mode_out.smartcard_enable)[*3] |-> !smartcard_clock_out; endproperty
    a_scclk: assert property (p_scclk) else $error("card clock outside card mode");
    property p_lptick; (!mode_out.infrared_low_power)[*2] |-> !lowpower_tick_out; endproperty
    a_lptick: assert property (p_lptick) else $error("low power tick outside low power");
endmodule
bind umc_mode_ctl umc_mode_ctl_chk i_chk (.*);

// ===== tb/umc_mode_ctl_tb.sv
// Testbench: register, flag and divider checks for the mode control block
`timescale 1ns/1ps
module umc_mode_ctl_tb;
    import umc_pkg::*;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        unit_en = 1'b0;
    logic        stop = 1'b0;
    umc_stat_s   stat = '0;
    logic [31:0] rdata, rdata_s, c_sc, c_lp;
    logic        baud, cts_n, hold, rts_n, txq, rxq, nack, tc, irq, sck, lpt;
    umc_ctl_s    mode;
    int          failures = 0;
    int          n_tests = 0;
    int          n;
    logic [10:0] r_ctl [10] = '{11'h080, 11'h000, 11'h040, 11'h030, 11'h010, 11'h100, 11'h041, 11'h001, 11'h400,
                                11'h041};
    logic [8:0]  r_st [10] = '{9'h008, 9'h01C, 9'h004, 9'h002, 9'h002, 9'h010, 9'h080, 9'h040, 9'h100, 9'h020};
    logic [4:0]  r_exp [10] = '{5'h10, 5'h00, 5'h08, 5'h04, 5'h00, 5'h02, 5'h01, 5'h00, 5'h01, 5'h01};
    always #5 clk = ~clk;
    umc_far_model i_far (.ref_clk_in(clk), .rstn_in(rstn), .stop_in(stop), .cts_n_out(cts_n), .baud_tick_out(baud));
    umc_mode_ctl i_dut (.ref_clk_in(clk), .rstn_in(rstn), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
        .rdata_out(rdata), .unit_enable_in(unit_en), .baud_tick_in(baud), .cts_n_in(cts_n), .stat_in(stat),
        .tx_hold_out(hold), .rts_n_out(rts_n), .tx_dma_req_out(txq), .rx_dma_req_out(rxq), .nack_out(nack),
        .transmission_complete_flag_out(tc), .irq_out(irq), .mode_out(mode), .smartcard_clock_out(sck),
        .lowpower_tick_out(lpt));
    // Reduced instance: only its register readback is compared
    umc_mode_ctl #(.SIMPLE_UART(1'b1), .NO_INFRARED(1'b1)) i_dut_small (.ref_clk_in(clk), .rstn_in(rstn),
        .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata_s), .unit_enable_in(unit_en),
        .baud_tick_in(baud), .cts_n_in(cts_n), .stat_in(stat), .tx_hold_out(), .rts_n_out(), .tx_dma_req_out(),
        .rx_dma_req_out(), .nack_out(), .transmission_complete_flag_out(), .irq_out(), .mode_out(),
        .smartcard_clock_out(), .lowpower_tick_out());
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask
    // Settle first so a divider restart does not skew the count
    task automatic count(input int cyc);
        logic p;
        repeat (8) @(posedge clk);
        #1;
        c_sc = 0;
        c_lp = 0;
        p = sck;
        repeat (cyc) begin
            @(posedge clk);
            #1;
            c_sc += 32'(sck & !p);
            c_lp += 32'(lpt);
            p = sck;
        end
    endtask
    task automatic close_out;
        $display("failures %0d n_tests %0d", failures, n_tests);
        if (failures == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        close_out();
    end
    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        #1;
        rd_chk(OFF_MODE_CTL2, 32'h0);
        rd_chk(OFF_GUARD_PSC, 32'h0);
        for (int i = 0; i < 10; i++) begin
            wr_reg(OFF_MODE_CTL2, 32'(r_ctl[i]));
            stat <= r_st[i];
            repeat (4) @(posedge clk);
            #1;
            chk(32'({txq, rxq, nack, rts_n, irq}), 32'(r_exp[i]));
            chk(32'(mode), 32'(r_ctl[i]));
        end
        wr_reg(OFF_MODE_CTL2, 32'hFFFF_FFFF);
        wr_reg(OFF_GUARD_PSC, 32'hFFFF_FFFF);
        wr_reg(8'h20, 32'hFFFF_FFFF);
        rd_chk(OFF_MODE_CTL2, 32'h0000_07FF);
        chk(rdata_s, 32'h0000_00CD);
        rd_chk(OFF_GUARD_PSC, 32'h0000_FFFF);
        chk(rdata_s, 32'h0000_00FF);
        rd_chk(8'h20, 32'h0);
        wr_reg(OFF_MODE_CTL2, 32'h0);
        wr_reg(OFF_GUARD_PSC, 32'h0301);
        unit_en <= 1'b1;
        @(posedge clk);
        wr_reg(OFF_MODE_CTL2, 32'h07FF);
        wr_reg(OFF_GUARD_PSC, 32'h00FF);
        rd_chk(OFF_MODE_CTL2, 32'h04C1);
        rd_chk(OFF_GUARD_PSC, 32'h0301);
        @(posedge clk);
        unit_en <= 1'b0;
        wr_reg(OFF_MODE_CTL2, 32'h0020);
        stat <= 9'h001;
        @(posedge clk);
        stat <= '0;
        #1;
        chk(32'(tc), 32'h0);
        n = 0;
        while (tc !== 1'b1 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(32'(n >= 8 && n <= 14), 32'h1);
        wr_reg(OFF_GUARD_PSC, 32'h00E2);
        count(40);
        chk(c_sc, 32'h0A);
        chk(c_lp, 32'h0);
        wr_reg(OFF_MODE_CTL2, 32'h0006);
        wr_reg(OFF_GUARD_PSC, 32'h0005);
        count(40);
        chk(c_sc, 32'h0);
        chk(c_lp, 32'h08);
        // Normal infrared keeps prescaler at one
        wr_reg(OFF_GUARD_PSC, 32'h0001);
        wr_reg(OFF_MODE_CTL2, 32'h0002);
        count(20);
        chk(c_lp, 32'h0);
        wr_reg(OFF_MODE_CTL2, 32'h0200);
        stop <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        chk(32'(hold), 32'h1);
        @(posedge clk);
        stop <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
        chk(32'(hold), 32'h0);
        wr_reg(OFF_MODE_CTL2, 32'h0);
        stop <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        chk(32'(hold), 32'h0);
        close_out();
    end
endmodule
